// File: design/dtc_timer_unit.sv
// Purpose: Dual 16-bit timer/counter with external interrupt detection
// Assumes: CPU core drives a byte-wide SFR bus on mclk_in; pins are asynchronous
// Notes:   Firmware writes override hardware updates except flag sets, external-flag ack clears and level-flag tracking at S1
`timescale 1ns/1ps
`default_nettype none
module dtc_timer_unit (
  input  wire logic       mclk_in,
  input  wire logic       rst_b_in,
  input  wire logic [7:0] sfr_addr_in,
  input  wire logic       sfr_wr_in,
  input  wire logic [7:0] sfr_wdata_in,
  input  wire logic [3:0] irq_ack_in,
  input  wire logic       count_input_a_pin_in,
  input  wire logic       count_input_b_pin_in,
  input  wire logic       ext_irq_a_pin_in,
  input  wire logic       ext_irq_b_pin_in,
  output logic      [7:0] sfr_rdata_out,
  output logic            overflow_flag_a_out,
  output logic            overflow_flag_b_out,
  output logic            ext_flag_a_out,
  output logic            ext_flag_b_out,
  output logic            timer_b_overflow_tick_out
);
  dtc_pkg::dtc_state_t st,        next_st;
  dtc_pkg::dtc_pins_t  sync1,     sync2;
  dtc_pkg::dtc_count_t cnt_a,     next_cnt_a;
  dtc_pkg::dtc_count_t cnt_b,     next_cnt_b;
  dtc_pkg::dtc_step_t  step_a,    step_b;
  logic [7:0]          ctrl,      next_ctrl;
  logic [7:0]          mode_sel,  next_mode_sel;
  logic [1:0]          samp,      next_samp;
  logic [1:0]          pend,      next_pend;
  logic [1:0]          irq_prev,  next_irq_prev;
  logic [1:0]          clr_a,     next_clr_a;
  logic [1:0]          clr_b,     next_clr_b;
  logic [7:0]          rdata,     next_rdata;
  logic                tick,      next_tick;
  logic [1:0]          mode_a,    mode_b;
  logic                split_a,   inc_a,     inc_ah,    inc_b;
  logic                set_ovf_a, set_ovf_b, tick_b;
  logic                set_ea,    set_eb;
  logic [8:0]          lo_a_inc,  hi_a_inc;
  logic                wr_ctrl,   wr_mode;

  // One step of a counter in the given mode; split and freeze leave it alone
  function automatic dtc_pkg::dtc_step_t dtc_step(input dtc_pkg::dtc_count_t c,
                                                  input logic [1:0] mode);
    dtc_pkg::dtc_step_t r;
    logic [16:0]        s17;
    logic [8:0]         s9;
    r     = '{cnt: c, ovf: 1'b0};
    s17   = 17'h0;
    s9    = 9'h0;
    case (mode)
      dtc_pkg::MODE_13BIT: begin
        s17      = {4'h0, c.hi, c.lo[4:0]} + 17'h1;
        r.cnt.hi = s17[12:5];
        r.cnt.lo = {c.lo[7:5], s17[4:0]};
        r.ovf    = s17[13];
      end
      dtc_pkg::MODE_16BIT: begin
        s17   = {1'b0, c} + 17'h1;
        r.cnt = s17[15:0];
        r.ovf = s17[16];
      end
      dtc_pkg::MODE_RELOAD: begin
        s9       = {1'b0, c.lo} + 9'h1;
        r.cnt.lo = s9[8] ? c.hi : s9[7:0];
        r.ovf    = s9[8];
      end
      default: r.ovf = 1'b0;
    endcase
    return r;
  endfunction : dtc_step

  assign mode_a   = mode_sel[dtc_pkg::MOD_MODE_A_HI:dtc_pkg::MOD_MODE_A_LO];
  assign mode_b   = mode_sel[dtc_pkg::MOD_MODE_B_HI:dtc_pkg::MOD_MODE_B_LO];
  assign split_a  = (mode_a == dtc_pkg::MODE_SPLIT);
  assign step_a   = dtc_step(cnt_a, mode_a);
  assign step_b   = dtc_step(cnt_b, mode_b);
  assign lo_a_inc = {1'b0, cnt_a.lo} + 9'h1;
  assign hi_a_inc = {1'b0, cnt_a.hi} + 9'h1;
  assign wr_ctrl  = sfr_wr_in && (sfr_addr_in == dtc_pkg::ADDR_TIMER_CONTROL);
  assign wr_mode  = sfr_wr_in && (sfr_addr_in == dtc_pkg::ADDR_TIMER_MODE_SELECT);

  // Counting happens once per machine cycle, in S3
  assign inc_a = (st == dtc_pkg::ST_S3) && ctrl[dtc_pkg::CTL_RUN_A]
              && (!mode_sel[dtc_pkg::MOD_GATE_A] || sync2.ext_irq_a_pin)
              && (!mode_sel[dtc_pkg::MOD_COUNTER_A] || pend[0]);
  assign inc_ah = (st == dtc_pkg::ST_S3) && split_a && ctrl[dtc_pkg::CTL_RUN_B];
  assign inc_b = (st == dtc_pkg::ST_S3) && ctrl[dtc_pkg::CTL_RUN_B]
              && (!mode_sel[dtc_pkg::MOD_GATE_B] || sync2.ext_irq_b_pin)
              && (!mode_sel[dtc_pkg::MOD_COUNTER_B] || pend[1]);
  assign set_ovf_a = inc_a && (split_a ? lo_a_inc[8] : step_a.ovf);
  assign tick_b    = inc_b && step_b.ovf;
  // In split mode timer B loses its flag to the upper byte of timer A
  assign set_ovf_b = split_a ? (inc_ah && hi_a_inc[8]) : tick_b;
  assign set_ea = (st == dtc_pkg::ST_S1) && irq_prev[0] && !sync2.ext_irq_a_pin;
  assign set_eb = (st == dtc_pkg::ST_S1) && irq_prev[1] && !sync2.ext_irq_b_pin;

  // Pins are asynchronous; the first stage feeds only the second
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      // Idle-high reset, else level flags fire on the first S1
      sync1 <= dtc_pkg::PIN_IDLE;
      sync2 <= dtc_pkg::PIN_IDLE;
    end else begin
      sync1 <= '{ext_irq_b_pin: ext_irq_b_pin_in, ext_irq_a_pin: ext_irq_a_pin_in,
                 count_input_b_pin: count_input_b_pin_in,
                 count_input_a_pin: count_input_a_pin_in};
      sync2 <= sync1;
    end
  end

  always_comb begin
    next_st       = st;
    next_samp     = samp;
    next_pend     = pend;
    next_irq_prev = irq_prev;
    next_ctrl     = wr_ctrl ? sfr_wdata_in : ctrl;
    next_mode_sel = wr_mode ? sfr_wdata_in : mode_sel;
    next_cnt_a    = cnt_a;
    next_cnt_b    = cnt_b;
    next_clr_a    = clr_a;
    next_clr_b    = clr_b;
    next_tick     = tick_b;
    next_rdata    = dtc_pkg::RESET_BYTE;
    case (st)
      dtc_pkg::ST_S1: next_st = dtc_pkg::ST_S2;
      dtc_pkg::ST_S2: next_st = dtc_pkg::ST_S3;
      dtc_pkg::ST_S3: next_st = dtc_pkg::ST_S4;
      dtc_pkg::ST_S4: next_st = dtc_pkg::ST_S5;
      dtc_pkg::ST_S5: next_st = dtc_pkg::ST_S6;
      default:        next_st = dtc_pkg::ST_S1;
    endcase
    // Two samples a machine cycle apart cap the count rate at clock / 12
    if (st == dtc_pkg::ST_S5) begin
      next_samp = {sync2.count_input_b_pin, sync2.count_input_a_pin};
      next_pend = samp & ~next_samp;
    end else if (st == dtc_pkg::ST_S4) begin
      next_pend = 2'h0;
    end
    // Interrupt pins compared S1 to S1 so no fall slips between samples
    if (st == dtc_pkg::ST_S1) begin
      next_irq_prev = {sync2.ext_irq_b_pin, sync2.ext_irq_a_pin};
    end
    // Hardware count updates, then firmware writes override them
    if (inc_a) begin
      if (split_a) begin
        next_cnt_a.lo = lo_a_inc[7:0];
      end else begin
        next_cnt_a = step_a.cnt;
      end
    end
    if (inc_ah) begin
      next_cnt_a.hi = hi_a_inc[7:0];
    end
    if (inc_b) begin
      next_cnt_b = step_b.cnt;
    end
    if (sfr_wr_in) begin
      case (sfr_addr_in)
        dtc_pkg::ADDR_TIMER_A_COUNT_LOW:  next_cnt_a.lo = sfr_wdata_in;
        dtc_pkg::ADDR_TIMER_A_COUNT_HIGH: next_cnt_a.hi = sfr_wdata_in;
        dtc_pkg::ADDR_TIMER_B_COUNT_LOW:  next_cnt_b.lo = sfr_wdata_in;
        dtc_pkg::ADDR_TIMER_B_COUNT_HIGH: next_cnt_b.hi = sfr_wdata_in;
        default:                          next_cnt_b = next_cnt_b;
      endcase
    end
    // Flag clear waits out machine-cycle boundaries after the acknowledge
    if (irq_ack_in[0]) begin
      next_clr_a = dtc_pkg::ACK_CLEAR_MCYCLES;
    end else if ((st == dtc_pkg::ST_S6) && (clr_a != 2'h0)) begin
      next_clr_a = clr_a - 2'h1;
    end
    if (irq_ack_in[1]) begin
      next_clr_b = dtc_pkg::ACK_CLEAR_MCYCLES;
    end else if ((st == dtc_pkg::ST_S6) && (clr_b != 2'h0)) begin
      next_clr_b = clr_b - 2'h1;
    end
    if ((st == dtc_pkg::ST_S6) && (clr_a == 2'h1) && !wr_ctrl) begin
      next_ctrl[dtc_pkg::CTL_OVERFLOW_FLAG_A] = 1'b0;
    end
    if ((st == dtc_pkg::ST_S6) && (clr_b == 2'h1) && !wr_ctrl) begin
      next_ctrl[dtc_pkg::CTL_OVERFLOW_FLAG_B] = 1'b0;
    end
    // A hardware set beats any clear in the same cycle
    if (set_ovf_a) begin
      next_ctrl[dtc_pkg::CTL_OVERFLOW_FLAG_A] = 1'b1;
    end
    if (set_ovf_b) begin
      next_ctrl[dtc_pkg::CTL_OVERFLOW_FLAG_B] = 1'b1;
    end
    // External interrupts: edge flags latch, level flags track the pin
    if (!ctrl[dtc_pkg::CTL_TRIGGER_TYPE_A]) begin
      if (st == dtc_pkg::ST_S1) begin
        next_ctrl[dtc_pkg::CTL_EXT_FLAG_A] = !sync2.ext_irq_a_pin;
      end
    end else if (set_ea) begin
      next_ctrl[dtc_pkg::CTL_EXT_FLAG_A] = 1'b1;
    end else if (irq_ack_in[2]) begin
      next_ctrl[dtc_pkg::CTL_EXT_FLAG_A] = 1'b0;
    end
    if (!ctrl[dtc_pkg::CTL_TRIGGER_TYPE_B]) begin
      if (st == dtc_pkg::ST_S1) begin
        next_ctrl[dtc_pkg::CTL_EXT_FLAG_B] = !sync2.ext_irq_b_pin;
      end
    end else if (set_eb) begin
      next_ctrl[dtc_pkg::CTL_EXT_FLAG_B] = 1'b1;
    end else if (irq_ack_in[3]) begin
      next_ctrl[dtc_pkg::CTL_EXT_FLAG_B] = 1'b0;
    end
    // Read data is registered; unmapped addresses read zero
    case (sfr_addr_in)
      dtc_pkg::ADDR_TIMER_CONTROL:      next_rdata = ctrl;
      dtc_pkg::ADDR_TIMER_MODE_SELECT:  next_rdata = mode_sel;
      dtc_pkg::ADDR_TIMER_A_COUNT_LOW:  next_rdata = cnt_a.lo;
      dtc_pkg::ADDR_TIMER_B_COUNT_LOW:  next_rdata = cnt_b.lo;
      dtc_pkg::ADDR_TIMER_A_COUNT_HIGH: next_rdata = cnt_a.hi;
      dtc_pkg::ADDR_TIMER_B_COUNT_HIGH: next_rdata = cnt_b.hi;
      default:                          next_rdata = dtc_pkg::RESET_BYTE;
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st       <= dtc_pkg::ST_S1;
      samp     <= 2'h0;
      pend     <= 2'h0;
      irq_prev <= 2'h0;
      ctrl     <= dtc_pkg::RESET_BYTE;
      mode_sel <= dtc_pkg::RESET_BYTE;
      cnt_a    <= '0;
      cnt_b    <= '0;
      clr_a    <= 2'h0;
      clr_b    <= 2'h0;
      rdata    <= dtc_pkg::RESET_BYTE;
      tick     <= 1'b0;
    end else begin
      st       <= next_st;
      samp     <= next_samp;
      pend     <= next_pend;
      irq_prev <= next_irq_prev;
      ctrl     <= next_ctrl;
      mode_sel <= next_mode_sel;
      cnt_a    <= next_cnt_a;
      cnt_b    <= next_cnt_b;
      clr_a    <= next_clr_a;
      clr_b    <= next_clr_b;
      rdata    <= next_rdata;
      tick     <= next_tick;
    end
  end

  assign sfr_rdata_out             = rdata;
  assign overflow_flag_a_out       = ctrl[dtc_pkg::CTL_OVERFLOW_FLAG_A];
  assign overflow_flag_b_out       = ctrl[dtc_pkg::CTL_OVERFLOW_FLAG_B];
  assign ext_flag_a_out            = ctrl[dtc_pkg::CTL_EXT_FLAG_A];
  assign ext_flag_b_out            = ctrl[dtc_pkg::CTL_EXT_FLAG_B];
  assign timer_b_overflow_tick_out = tick;

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_b_in);

  sequence s_fall_a;
    (st == dtc_pkg::ST_S5) && sync2.count_input_a_pin
    ##6 (st == dtc_pkg::ST_S5) && !sync2.count_input_a_pin;
  endsequence
  sequence s_count_ready_a;
    (ctrl[dtc_pkg::CTL_RUN_A] && !mode_sel[dtc_pkg::MOD_GATE_A] && !sfr_wr_in
     && mode_sel[dtc_pkg::MOD_COUNTER_A] && (mode_a == dtc_pkg::MODE_16BIT))[*5];
  endsequence

  property p_edge_pend;
    s_fall_a |=> pend[0];
  endproperty
  a_edge_pend: assert property (p_edge_pend) else $error("falling edge not latched");

  property p_edge_count;
    s_fall_a ##0 s_count_ready_a |=> cnt_a == 16'($past(cnt_a, 5) + 16'h1);
  endproperty
  a_edge_count: assert property (p_edge_count) else $error("edge count late");

  property p_timer_step;
    (st == dtc_pkg::ST_S3) && ctrl[dtc_pkg::CTL_RUN_A] && !mode_sel[dtc_pkg::MOD_GATE_A]
    && !mode_sel[dtc_pkg::MOD_COUNTER_A] && (mode_a == dtc_pkg::MODE_16BIT) && !sfr_wr_in
    |=> cnt_a == 16'($past(cnt_a) + 16'h1);
  endproperty
  a_timer_step: assert property (p_timer_step) else $error("timer did not step");

  property p_hold_outside_s3;
    (st != dtc_pkg::ST_S3) && !sfr_wr_in |=> $stable(cnt_a) && $stable(cnt_b);
  endproperty
  a_hold_outside_s3: assert property (p_hold_outside_s3) else $error("count moved");

  property p_gate_blocks;
    mode_sel[dtc_pkg::MOD_GATE_B] && !sync2.ext_irq_b_pin && !sfr_wr_in
    |=> $stable(cnt_b);
  endproperty
  a_gate_blocks: assert property (p_gate_blocks) else $error("gated timer counted");

  property p_reload;
    inc_b && !split_a && (mode_b == dtc_pkg::MODE_RELOAD) && (cnt_b.lo == 8'hff) && !sfr_wr_in
    |=> (cnt_b.lo == cnt_b.hi) && overflow_flag_b_out && timer_b_overflow_tick_out;
  endproperty
  a_reload: assert property (p_reload) else $error("reload or tick missing");

  property p_freeze_b;
    (mode_b == dtc_pkg::MODE_SPLIT) && !sfr_wr_in |=> $stable(cnt_b);
  endproperty
  a_freeze_b: assert property (p_freeze_b) else $error("frozen timer moved");

  property p_ack_clear;
    irq_ack_in[0] && !set_ovf_a ##1 (!set_ovf_a && !irq_ack_in[0] && !sfr_wr_in)[*8]
    ##0 (!set_ovf_a && !irq_ack_in[0] && !sfr_wr_in)[*5]
    |=> !overflow_flag_a_out;
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("flag not cleared");

  property p_level_mode;
    !ctrl[dtc_pkg::CTL_TRIGGER_TYPE_A] && (st == dtc_pkg::ST_S1) && !sfr_wr_in
    |=> ext_flag_a_out == !$past(sync2.ext_irq_a_pin);
  endproperty
  a_level_mode: assert property (p_level_mode) else $error("level flag wrong");
endmodule : dtc_timer_unit
`default_nettype wire

// File: inc/dtc_pkg.sv
// Purpose: Shared constants and types for the dual timer/counter unit
// Assumes: Byte-wide SFR bus, 100 MHz CPU clock, six states per machine cycle
// Notes:   All register offsets and bit positions live here, plus the control, mode, read-data and pin-sync reset values
package dtc_pkg;
  // Register map
  localparam logic [7:0] ADDR_TIMER_CONTROL     = 8'h88;
  localparam logic [7:0] ADDR_TIMER_MODE_SELECT = 8'h89;
  localparam logic [7:0] ADDR_TIMER_A_COUNT_LOW  = 8'h8a;
  localparam logic [7:0] ADDR_TIMER_B_COUNT_LOW  = 8'h8b;
  localparam logic [7:0] ADDR_TIMER_A_COUNT_HIGH = 8'h8c;
  localparam logic [7:0] ADDR_TIMER_B_COUNT_HIGH = 8'h8d;
  localparam logic [7:0] RESET_BYTE             = 8'h00;
  localparam logic [3:0] PIN_IDLE               = 4'hf;

  // timer_control bits
  localparam int CTL_OVERFLOW_FLAG_B = 7;
  localparam int CTL_RUN_B           = 6;
  localparam int CTL_OVERFLOW_FLAG_A = 5;
  localparam int CTL_RUN_A           = 4;
  localparam int CTL_EXT_FLAG_B      = 3;
  localparam int CTL_TRIGGER_TYPE_B  = 2;
  localparam int CTL_EXT_FLAG_A      = 1;
  localparam int CTL_TRIGGER_TYPE_A  = 0;

  // timer_mode_select bits
  localparam int MOD_GATE_B    = 7;
  localparam int MOD_COUNTER_B = 6;
  localparam int MOD_MODE_B_HI = 5;
  localparam int MOD_MODE_B_LO = 4;
  localparam int MOD_GATE_A    = 3;
  localparam int MOD_COUNTER_A = 2;
  localparam int MOD_MODE_A_HI = 1;
  localparam int MOD_MODE_A_LO = 0;

  // Mode encodings
  localparam logic [1:0] MODE_13BIT  = 2'h0;
  localparam logic [1:0] MODE_16BIT  = 2'h1;
  localparam logic [1:0] MODE_RELOAD = 2'h2;
  localparam logic [1:0] MODE_SPLIT  = 2'h3;

  // Timing
  localparam int         CPU_CLK_MHZ       = 100;
  localparam int         STATES_PER_MCYCLE = 6;
  localparam logic [1:0] ACK_CLEAR_MCYCLES = 2'h2;

  typedef enum {ST_S1, ST_S2, ST_S3, ST_S4, ST_S5, ST_S6} dtc_state_t;

  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
  } dtc_count_t;

  typedef struct packed {
    dtc_count_t cnt;
    logic       ovf;
  } dtc_step_t;

  typedef struct packed {
    logic ext_irq_b_pin;
    logic ext_irq_a_pin;
    logic count_input_b_pin;
    logic count_input_a_pin;
  } dtc_pins_t;
endpackage : dtc_pkg

// File: test/dtc_cpu_model.sv
// Purpose: CPU core model that drives the SFR bus of the timer unit
// Assumes: Requests change on falling edges, taken on the next rising edge
// Notes:   Bus data is inverted after a write so stale bytes never look valid
`timescale 1ns/1ps
`default_nettype none
module dtc_cpu_model (
  input  wire logic       mclk_in,
  input  wire logic [7:0] sfr_rdata_in,
  output logic      [7:0] sfr_addr_out,
  output logic            sfr_wr_out,
  output logic      [7:0] sfr_wdata_out,
  output logic      [3:0] irq_ack_out
);
  initial begin
    sfr_addr_out  = 8'h00;
    sfr_wr_out    = 1'b0;
    sfr_wdata_out = 8'h00;
    irq_ack_out   = 4'h0;
  end

  // One-cycle write strobe, one idle cycle before the next request
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_in);
    sfr_addr_out  = a;
    sfr_wr_out    = 1'b1;
    sfr_wdata_out = d;
    @(negedge mclk_in);
    sfr_wr_out    = 1'b0;
    sfr_wdata_out = ~d;
  endtask : wr

  // Read data is registered, so it is taken one cycle after the address
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk_in);
    sfr_addr_out = a;
    @(negedge mclk_in);
    d = sfr_rdata_in;
  endtask : rd

  // Acks only on request; mask m is held for one cycle
  task automatic ack(input logic [3:0] m);
    @(negedge mclk_in);
    irq_ack_out = m;
    @(negedge mclk_in);
    irq_ack_out = 4'h0;
  endtask : ack
endmodule : dtc_cpu_model
`default_nettype wire

// File: test/dtc_timer_unit_tb.sv
// Purpose: Self-checking bench for the dual timer/counter unit
// Assumes: CPU model drives the bus; pins driven here at falling edges
// Notes:   Mode rows in a table; reset, counter and external cases by hand
`timescale 1ns/1ps
`default_nettype none
module dtc_timer_unit_tb;
  typedef struct packed {
    logic [7:0]  mod;
    logic        pin;
    logic [7:0]  ctl;
    logic [15:0] a;
    logic [15:0] b;
    logic [3:0]  k;
    logic [15:0] ea;
    logic [15:0] eb;
    logic [7:0]  eflg;
    logic        etk;
  } dtc_row_t;
  logic        mclk;
  logic        rst_b;
  logic [7:0]  addr;
  logic        wr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic [3:0]  ack;
  logic [1:0]  cnt_pin;
  logic [1:0]  ext_pin;
  logic        ovf_a;
  logic        ovf_b;
  logic        ext_a;
  logic        ext_b;
  logic        tick;
  logic [7:0]  lo;
  logic [15:0] v;
  dtc_row_t    r;
  int          n_errors;
  int          checks_done;
  int          n_tick;
  // Overflow steps are kept off the last step so flag checks are phase-safe
  dtc_row_t rows [9] = '{
    '{8'h01, 1'b1, 8'h10, 16'hfffe, 16'h0000, 4'h3, 16'h0001, 16'h0000, 8'h20, 1'b0},
    '{8'h00, 1'b1, 8'h10, 16'h001e, 16'h0000, 4'h3, 16'h0101, 16'h0000, 8'h00, 1'b0},
    '{8'h02, 1'b1, 8'h10, 16'h40fe, 16'h0000, 4'h3, 16'h4041, 16'h0000, 8'h20, 1'b0},
    '{8'h10, 1'b1, 8'h40, 16'h0000, 16'hfffe, 4'h3, 16'h0000, 16'h0001, 8'h80, 1'b1},
    '{8'h30, 1'b1, 8'h40, 16'h0000, 16'h1234, 4'h4, 16'h0000, 16'h1234, 8'h00, 1'b0},
    '{8'h03, 1'b1, 8'h50, 16'hfefe, 16'h0000, 4'h3, 16'h0101, 16'h0003, 8'ha0, 1'b0},
    '{8'h20, 1'b1, 8'h40, 16'h0000, 16'hf0fe, 4'h3, 16'h0000, 16'hf0f1, 8'h80, 1'b1},
    '{8'h99, 1'b0, 8'h50, 16'h0000, 16'h0000, 4'h3, 16'h0000, 16'h0000, 8'h0a, 1'b0},
    '{8'h99, 1'b1, 8'h50, 16'h0000, 16'h0000, 4'h3, 16'h0003, 16'h0003, 8'h00, 1'b0}};

  dtc_timer_unit i_dtc_timer_unit (
    .mclk_in                   (mclk),
    .rst_b_in                  (rst_b),
    .sfr_addr_in               (addr),
    .sfr_wr_in                 (wr),
    .sfr_wdata_in              (wdata),
    .irq_ack_in                (ack),
    .count_input_a_pin_in      (cnt_pin[0]),
    .count_input_b_pin_in      (cnt_pin[1]),
    .ext_irq_a_pin_in          (ext_pin[0]),
    .ext_irq_b_pin_in          (ext_pin[1]),
    .sfr_rdata_out             (rdata),
    .overflow_flag_a_out       (ovf_a),
    .overflow_flag_b_out       (ovf_b),
    .ext_flag_a_out            (ext_a),
    .ext_flag_b_out            (ext_b),
    .timer_b_overflow_tick_out (tick)
  );

  dtc_cpu_model i_dtc_cpu_model (
    .mclk_in       (mclk),
    .sfr_rdata_in  (rdata),
    .sfr_addr_out  (addr),
    .sfr_wr_out    (wr),
    .sfr_wdata_out (wdata),
    .irq_ack_out   (ack)
  );

  always #5 mclk = ~mclk;

  always @(negedge mclk) begin
    if (tick === 1'b1) begin
      n_tick++;
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic rd16(input logic [7:0] al, input logic [7:0] ah, output logic [15:0] d);
    i_dtc_cpu_model.rd(al, d[7:0]);
    i_dtc_cpu_model.rd(ah, d[15:8]);
  endtask : rd16

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    $display("watchdog expired");
    print_verdict();
  end

  initial begin
    mclk    = 1'b0;
    rst_b   = 1'b0;
    cnt_pin = 2'h3;
    ext_pin = 2'h3;
    repeat (16) @(negedge mclk);
    rst_b = 1'b1;
    for (int a = 8'h88; a <= 8'h8e; a++) begin
      i_dtc_cpu_model.rd(8'(a), lo);
      chk({8'h00, lo}, 16'h0000);
    end
    i_dtc_cpu_model.wr(8'h8f, 8'hff);
    i_dtc_cpu_model.rd(8'h8f, lo);
    chk({8'h00, lo}, 16'h0000);
    i_dtc_cpu_model.wr(dtc_pkg::ADDR_TIMER_MODE_SELECT, 8'ha5);
    i_dtc_cpu_model.rd(dtc_pkg::ADDR_TIMER_MODE_SELECT, lo);
    chk({8'h00, lo}, 16'h00a5);
    $display("register test done");
    for (int i = 0; i < 9; i++) begin
      r = rows[i];
      ext_pin = {r.pin, r.pin};
      i_dtc_cpu_model.wr(dtc_pkg::ADDR_TIMER_MODE_SELECT, r.mod);
      i_dtc_cpu_model.wr(dtc_pkg::ADDR_TIMER_A_COUNT_LOW, r.a[7:0]);
      i_dtc_cpu_model.wr(dtc_pkg::ADDR_TIMER_A_COUNT_HIGH, r.a[15:8]);
      i_dtc_cpu_model.wr(dtc_pkg::ADDR_TIMER_B_COUNT_LOW, r.b[7:0]);
      i_dtc_cpu_model.wr(dtc_pkg::ADDR_TIMER_B_COUNT_HIGH, r.b[15:8]);
      n_tick = 0;
      // Run window is exactly k machine cycles of write-to-write spacing
      i_dtc_cpu_model.wr(dtc_pkg::ADDR_TIMER_CONTROL, r.ctl);
      repeat (6 * r.k - 2) @(negedge mclk);
      chk({14'h0, ovf_b, ovf_a}, {14'h0, r.eflg[7], r.eflg[5]});
      i_dtc_cpu_model.wr(dtc_pkg::ADDR_TIMER_CONTROL, r.eflg);
      rd16(dtc_pkg::ADDR_TIMER_A_COUNT_LOW, dtc_pkg::ADDR_TIMER_A_COUNT_HIGH, v);
      chk(v, r.ea);
      rd16(dtc_pkg::ADDR_TIMER_B_COUNT_LOW, dtc_pkg::ADDR_TIMER_B_COUNT_HIGH, v);
      chk(v, r.eb);
      i_dtc_cpu_model.rd(dtc_pkg::ADDR_TIMER_CONTROL, lo);
      chk({8'h00, lo}, {8'h00, r.eflg});
      chk(16'(n_tick), {15'h0, r.etk});
      if (r.eflg !== 8'h00) begin
        i_dtc_cpu_model.ack({2'h0, r.eflg[7], r.eflg[5]});
        repeat (4) @(negedge mclk);
        chk({14'h0, ovf_b, ovf_a}, {14'h0, r.eflg[7], r.eflg[5]});
        repeat (10) @(negedge mclk);
        chk({14'h0, ovf_b, ovf_a}, 16'h0000);
      end
      $display("row %0d done", i);
    end
    for (int t = 0; t < 2; t++) begin
      i_dtc_cpu_model.wr(dtc_pkg::ADDR_TIMER_MODE_SELECT, t ? 8'h50 : 8'h05);
      i_dtc_cpu_model.wr(t ? 8'h8b : 8'h8a, 8'h00);
      i_dtc_cpu_model.wr(t ? 8'h8d : 8'h8c, 8'h00);
      i_dtc_cpu_model.wr(dtc_pkg::ADDR_TIMER_CONTROL, t ? 8'h40 : 8'h10);
      repeat (5) begin
        cnt_pin[t] = 1'b0;
        repeat (6) @(negedge mclk);
        cnt_pin[t] = 1'b1;
        repeat (6) @(negedge mclk);
      end
      repeat (18) @(negedge mclk);
      i_dtc_cpu_model.wr(dtc_pkg::ADDR_TIMER_CONTROL, 8'h00);
      i_dtc_cpu_model.rd(t ? 8'h8b : 8'h8a, lo);
      chk({8'h00, lo}, 16'h0005);
      $display("counter %0d done", t);
    end
    for (int i = 0; i < 2; i++) begin
      i_dtc_cpu_model.wr(dtc_pkg::ADDR_TIMER_CONTROL, i ? 8'h04 : 8'h01);
      ext_pin[i] = 1'b0;
      repeat (12) @(negedge mclk);
      ext_pin[i] = 1'b1;
      repeat (12) @(negedge mclk);
      chk({15'h0, i ? ext_b : ext_a}, 16'h0001);
      i_dtc_cpu_model.ack(i ? 4'h8 : 4'h4);
      repeat (12) @(negedge mclk);
      chk({15'h0, i ? ext_b : ext_a}, 16'h0000);
      i_dtc_cpu_model.wr(dtc_pkg::ADDR_TIMER_CONTROL, 8'h00);
      ext_pin[i] = 1'b0;
      repeat (12) @(negedge mclk);
      chk({15'h0, i ? ext_b : ext_a}, 16'h0001);
      ext_pin[i] = 1'b1;
      repeat (12) @(negedge mclk);
      chk({15'h0, i ? ext_b : ext_a}, 16'h0000);
      $display("external input %0d done", i);
    end
    i_dtc_cpu_model.wr(dtc_pkg::ADDR_TIMER_MODE_SELECT, 8'h5a);
    i_dtc_cpu_model.wr(dtc_pkg::ADDR_TIMER_B_COUNT_HIGH, 8'h3c);
    rst_b = 1'b0;
    repeat (3) @(negedge mclk);
    rst_b = 1'b1;
    i_dtc_cpu_model.rd(dtc_pkg::ADDR_TIMER_MODE_SELECT, lo);
    chk({8'h00, lo}, {8'h00, dtc_pkg::RESET_BYTE});
    i_dtc_cpu_model.rd(dtc_pkg::ADDR_TIMER_B_COUNT_HIGH, lo);
    chk({8'h00, lo}, {8'h00, dtc_pkg::RESET_BYTE});
    $display("mid-run reset done");
    print_verdict();
  end
endmodule : dtc_timer_unit_tb
`default_nettype wire
